// ==== verilog/pceint_pkg.sv ====
package pceint_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_PA_RISE = 6'h00;
  localparam logic [5:0] ADDR_PA_FALL = 6'h04;
  localparam logic [5:0] ADDR_PA_FLAGS = 6'h08;
  localparam logic [5:0] ADDR_PC_RISE = 6'h0C;
  localparam logic [5:0] ADDR_PC_FALL = 6'h10;
  localparam logic [5:0] ADDR_PC_FLAGS = 6'h14;
  localparam logic [5:0] ADDR_CTRL = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h20;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam logic [5:0] PIN_RESET = 6'h00;
  localparam logic [5:0] DEBUG_PINS = 6'h03;
  localparam int CTRL_MASTER_BIT = 0;
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_BITS = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [PIN_COUNT-1:0] pceint_pins_t;

endpackage

// ==== verilog/pceint_edge.sv ====
`timescale 1ns/10ps
`default_nettype none
module pceint_edge #(
  parameter int WIDTH = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } pceint_edge_s;

  pceint_edge_s st;
  pceint_edge_s next_st;

  // ---------------------------------------------------------------
  // Three-stage sync, edge when stages two and three differ
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = st.s2 & ~st.s3;
    next_st.fall = ~st.s2 & st.s3;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
  assign fall = st.fall;
endmodule
`default_nettype wire

// ==== verilog/pceint_top.sv ====
// Summary of operation
// - Wake from sleep only with master enable.
// - First port rise enables arm rising detection.
// - First port fall enables arm falling detection.
// - Enabled edge sets the pin change flag.
// - Setting a flag also sets global flag.
// - Flags stay set until software writes zero or the debugger takes their pin.
// - Bits seven and six ignore writes, read zero.
// - All enables and flags reset to zero.
// - Debugger takes first port bits one, zero.
// - Larger variant adds second port rise enables.
// - Global flag is OR of all flags.
// - Master enable clear: flags set, no pin change irq or wake; irq output not gated.
// - Edge during flag write leaves flag set.
// - Larger variant adds second port fall enables.
`timescale 1ns/10ps
`default_nettype none
module pceint_top
  import pceint_pkg::*;
#(
  parameter bit HAS_PORTC = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] first_port_pin,
  input wire logic [5:0] second_port_pin,
  input wire logic debugger_enabled,
  input wire logic core_sleeping,
  output logic pin_change_global_flag,
  output logic pin_change_irq,
  output logic wake_request,
  output logic irq
);
  import pceint_pkg::*;

  typedef struct packed {
    logic aw_full;
    logic [5:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    pceint_pins_t porta_rise_enable;
    pceint_pins_t porta_fall_enable;
    pceint_pins_t porta_change_flags;
    pceint_pins_t portc_rise_enable;
    pceint_pins_t portc_fall_enable;
    pceint_pins_t portc_change_flags;
    logic pin_change_master_enable;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic global_flag;
    logic pc_irq;
    logic wake;
    logic irq;
  } pceint_s;

  pceint_s st;
  pceint_s next_st;

  pceint_pins_t pa_rise;
  pceint_pins_t pa_fall;
  pceint_pins_t pc_rise;
  pceint_pins_t pc_fall;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detectors
  // ---------------------------------------------------------------
  pceint_edge #(
    .WIDTH(2*PIN_COUNT)
  ) pceint_edge_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({second_port_pin, first_port_pin}),
    .rise({pc_rise, pa_rise}),
    .fall({pc_fall, pa_fall})
  );

  pceint_pins_t pa_avail;
  pceint_pins_t pc_avail;
  pceint_pins_t pa_hit;
  pceint_pins_t pc_hit;
  logic wr_fire;
  logic [7:0] wbyte;

  always_comb
  begin
    pa_avail = debugger_enabled ? ~DEBUG_PINS : '1;
    pc_avail = HAS_PORTC ? '1 : '0;
    pa_hit = pa_avail & ((st.porta_rise_enable & pa_rise)
      | (st.porta_fall_enable & pa_fall));
    pc_hit = pc_avail & ((st.portc_rise_enable & pc_rise)
      | (st.portc_fall_enable & pc_fall));
  end

  // ---------------------------------------------------------------
  // Register bus, flags and interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    wr_fire = st.aw_full && st.w_full && !st.bvalid;
    wbyte = st.w_strb[0] ? st.w_data[7:0] : 8'h00;

    if (s_axi_awvalid && !st.aw_full)
    begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_full)
    begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end

    if (wr_fire)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.w_strb[0])
      begin
        unique case ({st.aw_addr[5:2], 2'b00})
          ADDR_PA_RISE: next_st.porta_rise_enable = wbyte[5:0];
          ADDR_PA_FALL: next_st.porta_fall_enable = wbyte[5:0];
          ADDR_PA_FLAGS: next_st.porta_change_flags = st.porta_change_flags & wbyte[5:0];
          ADDR_PC_RISE: next_st.portc_rise_enable = wbyte[5:0] & pc_avail;
          ADDR_PC_FALL: next_st.portc_fall_enable = wbyte[5:0] & pc_avail;
          ADDR_PC_FLAGS: next_st.portc_change_flags = st.portc_change_flags & wbyte[5:0];
          ADDR_CTRL: next_st.pin_change_master_enable = wbyte[CTRL_MASTER_BIT];
          ADDR_IRQ_STATUS: next_st.irq_status = st.irq_status & ~wbyte[IRQ_BITS-1:0];
          ADDR_IRQ_MASK: next_st.irq_mask = wbyte[IRQ_BITS-1:0];
          default: next_st.bresp = RESP_SLVERR;
        endcase
      end
      else if (!(({st.aw_addr[5:2], 2'b00}) <= ADDR_IRQ_MASK))
      begin
        next_st.bresp = RESP_SLVERR;
      end
    end

    // Hardware set wins over a concurrent software clear
    next_st.porta_change_flags = next_st.porta_change_flags | pa_hit;
    next_st.portc_change_flags = next_st.portc_change_flags | pc_hit;
    next_st.porta_change_flags = next_st.porta_change_flags & pa_avail;

    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[5:2], 2'b00})
        ADDR_PA_RISE: next_st.rdata[5:0] = st.porta_rise_enable & pa_avail;
        ADDR_PA_FALL: next_st.rdata[5:0] = st.porta_fall_enable & pa_avail;
        ADDR_PA_FLAGS: next_st.rdata[5:0] = st.porta_change_flags;
        ADDR_PC_RISE: next_st.rdata[5:0] = st.portc_rise_enable;
        ADDR_PC_FALL: next_st.rdata[5:0] = st.portc_fall_enable;
        ADDR_PC_FLAGS: next_st.rdata[5:0] = st.portc_change_flags;
        ADDR_CTRL: next_st.rdata[CTRL_MASTER_BIT] = st.pin_change_master_enable;
        ADDR_IRQ_STATUS: next_st.rdata[IRQ_BITS-1:0] = st.irq_status;
        ADDR_IRQ_MASK: next_st.rdata[IRQ_BITS-1:0] = st.irq_mask;
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end

    next_st.global_flag = |{next_st.porta_change_flags, next_st.portc_change_flags};
    next_st.pc_irq = next_st.global_flag & next_st.pin_change_master_enable;
    next_st.wake = next_st.pc_irq & core_sleeping;
    // Sticky status: set wins over write-one-clear
    next_st.irq_status[IRQ_GLOBAL_BIT] = next_st.irq_status[IRQ_GLOBAL_BIT]
      | (|{pa_hit, pc_hit});
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.aw_full;
  assign s_axi_wready = !st.w_full;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign pin_change_global_flag = st.global_flag;
  assign pin_change_irq = st.pc_irq;
  assign wake_request = st.wake;
  assign irq = st.irq;
endmodule
`default_nettype wire

// ==== test/pceint_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module pceint_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] first_port_pin,
  input wire logic [5:0] second_port_pin,
  input wire logic core_sleeping,
  input wire logic pin_change_global_flag,
  input wire logic pin_change_irq,
  input wire logic wake_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] pins_q;
  logic [3:0] since_chg;
  // Cycles since any pin moved
  always_ff @(posedge aclk)
  begin
    pins_q <= {first_port_pin, second_port_pin};
    if (!aresetn)
      since_chg <= 4'hF;
    else if (pins_q != {first_port_pin, second_port_pin})
      since_chg <= 4'h0;
    else if (since_chg != 4'hF)
      since_chg <= since_chg + 4'h1;
  end
  AST_WAKE: assert property (wake_request |-> $past(core_sleeping) &&
    (pin_change_irq || $past(pin_change_irq))) else $error("wake without cause");
  AST_IRQ_FLAG: assert property (pin_change_irq |-> pin_change_global_flag ||
    $past(pin_change_global_flag)) else $error("irq without flag");
  AST_FLAG_CAUSE: assert property ($rose(pin_change_global_flag) |-> since_chg < 4'h8)
    else $error("flag without pin edge");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  AST_ARREADY: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  AST_RDATA_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
    else $error("upper bits set");
  AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  cover property (wake_request);
  cover property ($rose(pin_change_global_flag));
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pceint_top pceint_checker pceint_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .first_port_pin(first_port_pin),
  .second_port_pin(second_port_pin), .core_sleeping(core_sleeping),
  .pin_change_global_flag(pin_change_global_flag), .pin_change_irq(pin_change_irq),
  .wake_request(wake_request));
`default_nettype wire

// ==== test/pceint_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pceint_pin_model (
  input wire logic aclk,
  input wire logic [5:0] a_level,
  input wire logic [5:0] c_level,
  input wire logic sleep_level,
  output logic [5:0] first_port_pin,
  output logic [5:0] second_port_pin,
  output logic core_sleeping
);
  // Pins and core state move just after an edge
  always_ff @(posedge aclk)
  begin
    first_port_pin <= a_level;
    second_port_pin <= c_level;
    core_sleeping <= sleep_level;
  end
endmodule
`default_nettype wire

// ==== test/pceint_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module pceint_top_bench;
  import pceint_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, dbg = 0, slp = 0;
  logic [5:0] awa = 0, ara = 0, pa = 0, pc = 0, fa, fc;
  logic [31:0] wd = 0, rdat, d;
  logic [3:0] ws = 4'hF;
  logic [1:0] bresp, rresp, r, wresp;
  logic awr, wrd, bv, arr, rv, gf, pirq, wake, irq, slept;
  int n_fail = 0, total_checks = 0;
  always #5 aclk = ~aclk;
  pceint_pin_model pceint_pin_model_inst (.aclk(aclk), .a_level(pa), .c_level(pc),
    .sleep_level(slp), .first_port_pin(fa), .second_port_pin(fc), .core_sleeping(slept));
  pceint_top pceint_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .first_port_pin(fa), .second_port_pin(fc), .debugger_enabled(dbg),
    .core_sleeping(slept), .pin_change_global_flag(gf), .pin_change_irq(pirq),
    .wake_request(wake), .irq(irq));
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end
    while (!bv);
    wresp = bresp;
    bre <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rre <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end
    while (!rv);
    d = rdat;
    r = rresp;
    rre <= 1'h0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, d, e);
  endtask
  task automatic pins(input logic [5:0] a, input logic [5:0] c);
    @(posedge aclk);
    pa <= a;
    pc <= c;
    repeat (8) @(posedge aclk);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rchk("reset", 6'(4 * i), 32'h0);
    rd(6'h24);
    chk("unmapped", {d[31:2], r}, {30'h0, RESP_SLVERR});
    wr(ADDR_PA_RISE, 8'hFF);
    rchk("rsvd", ADDR_PA_RISE, 32'h3F);
    wr(6'h24, 8'h01);
    chk("wunmapped", wresp, {30'h0, RESP_SLVERR});
    ws <= 4'h0;
    wr(ADDR_PA_RISE, 8'h00);
    ws <= 4'hF;
    chk("wokay", wresp, {30'h0, RESP_OKAY});
    rchk("nostrb", ADDR_PA_RISE, 32'h3F);
    $display("t_reset done");
  endtask
  task automatic t_edges();
    wr(ADDR_PA_RISE, 8'h05);
    wr(ADDR_PA_FALL, 8'hCA);
    pins(6'h3F, 6'h00);
    rchk("rise", ADDR_PA_FLAGS, 32'h05);
    chk("gflag", gf, 32'h1);
    pins(6'h00, 6'h00);
    rchk("fall", ADDR_PA_FLAGS, 32'h0F);
    wr(ADDR_PC_RISE, 8'h0F);
    wr(ADDR_PC_FALL, 8'hF0);
    rchk("cfall", ADDR_PC_FALL, 32'h30);
    pins(6'h00, 6'h3F);
    pins(6'h00, 6'h00);
    rchk("cflag", ADDR_PC_FLAGS, 32'h3F);
    $display("t_edges done");
  endtask
  task automatic t_clear();
    wr(ADDR_PA_FLAGS, 8'hFA);
    rchk("clr", ADDR_PA_FLAGS, 32'h0A);
    wr(ADDR_PA_FLAGS, 8'h00);
    chk("gflag", gf, 32'h1);
    wr(ADDR_PC_FLAGS, 8'h00);
    repeat (2) @(posedge aclk);
    chk("gflag0", gf, 32'h0);
    // Edge lands in the same cycle as the clearing write
    @(posedge aclk);
    pa <= 6'h04;
    repeat (2) @(posedge aclk);
    wr(ADDR_PA_FLAGS, 8'h00);
    rchk("collide", ADDR_PA_FLAGS, 32'h04);
    wr(ADDR_PA_FLAGS, 8'h00);
    $display("t_clear done");
  endtask
  task automatic t_irq();
    slp <= 1'h1;
    pins(6'h01, 6'h00);
    chk("noirq", {gf, pirq, wake}, 32'h4);
    wr(ADDR_CTRL, 8'h01);
    repeat (3) @(posedge aclk);
    chk("wake", {pirq, wake, irq}, 32'h6);
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge aclk);
    chk("irq", irq, 32'h1);
    wr(ADDR_PA_FLAGS, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge aclk);
    chk("irqclr", {irq, wake}, 32'h0);
    slp <= 1'h0;
    $display("t_irq done");
  endtask
  task automatic t_debug();
    dbg <= 1'h1;
    wr(ADDR_PA_RISE, 8'hFF);
    rchk("dbgen", ADDR_PA_RISE, {26'h0, ~DEBUG_PINS});
    pins(6'h03, 6'h00);
    rchk("dbgflag", ADDR_PA_FLAGS, 32'h0);
    dbg <= 1'h0;
    $display("t_debug done");
  endtask
  task automatic t_rerun();
    pins(6'h03, 6'h3F);
    chk("prerst", gf, 32'h1);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk("rstout", {gf, pirq, wake, irq}, 32'h0);
    for (int i = 0; i < 9; i++) rchk("rerun", 6'(4 * i), 32'h0);
    $display("t_rerun done");
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_edges();
    t_clear();
    t_irq();
    t_debug();
    t_rerun();
    conclude();
  end
  initial
  begin
    repeat (4000) @(posedge aclk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
